/* File: include/hsl_pkg.sv */
// shared types and constants for the hard strap latch and decode block
package hsl_pkg;

   // ***************************************************************
   // widths and reset values
   // ***************************************************************
   localparam int unsigned LED_W     = 6;
   localparam int unsigned P0_PIN_W  = 3;
   localparam logic [5:0]  LED_POL_RST  = 6'h00;
   localparam logic [2:0]  P0_PINS_RST  = 3'h0;
   localparam logic [1:0]  MGMT_PINS_RST = 2'h0;

   // shared pin positions: pin index n carries led polarity bit n
   localparam int unsigned PIN_PHYADDR = 5;
   localparam int unsigned PIN_MGMT1   = 4;
   localparam int unsigned PIN_MGMT0   = 3;
   localparam int unsigned PIN_EESIZE  = 2;
   localparam int unsigned PIN_MDIX2   = 1;
   localparam int unsigned PIN_MDIX1   = 0;

   // port 0 select pin positions feeding the virtual phy defaults
   localparam int unsigned P0_PIN_DIR   = 1;
   localparam int unsigned P0_PIN_DRIVE = 0;

   // ***************************************************************
   // modes and states
   // ***************************************************************
   typedef enum logic [1:0] {
      HSL_MGMT_RSVD_LO,
      HSL_MGMT_SMI,
      HSL_MGMT_I2C,
      HSL_MGMT_RSVD_HI
   } hsl_mgmt_e;

   typedef enum logic [1:0] {
      HSL_P0_MII_MAC,
      HSL_P0_MII_PHY,
      HSL_P0_RMII_PHY,
      HSL_P0_RSVD
   } hsl_p0_mode_e;

   typedef enum logic {
      HSL_ST_WAIT,
      HSL_ST_HOLD
   } hsl_state_e;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic [1:0] mgmt_bits;
      logic       eeprom_size;
      logic       phy_addr_sel;
      logic       auto_mdix_2;
      logic       auto_mdix_1;
      logic [5:0] led_pol;
      logic [2:0] p0_pins;
   } hsl_strap_s;

   typedef struct packed {
      logic refclk_dir;
      logic clk_drive;
      logic turbo_en;
   } hsl_vphy_s;

   localparam hsl_vphy_s VPHY_RST = 3'h0;

endpackage

/* File: rtl/hsl_port0_decode.sv */
// three-pin to two-bit decode of the port 0 interface mode
`timescale 1ns/1ps
module hsl_port0_decode (
   input  wire logic [2:0]            port0_select_pins,
   output hsl_pkg::hsl_p0_mode_e      port0_iface_select,
   output logic                       port0_reserved
);

   always_comb begin
      unique case (port0_select_pins)
         3'h0: port0_iface_select = hsl_pkg::HSL_P0_MII_MAC;
         3'h1, 3'h2, 3'h3: port0_iface_select = hsl_pkg::HSL_P0_MII_PHY;
         3'h4, 3'h5, 3'h6: port0_iface_select = hsl_pkg::HSL_P0_RMII_PHY;
         3'h7: port0_iface_select = hsl_pkg::HSL_P0_RSVD;
      endcase
      port0_reserved = (port0_iface_select == hsl_pkg::HSL_P0_RSVD);
   end

endmodule

/* File: rtl/hsl_strap_latch.sv */
// hard strap latch, decode, virtual phy defaults and led pin drive
//
// Function
// - straps sampled only on power-on or pin reset
// - straps come only from pins, never loader
// - each strap feeds config or register default
// - management strap 01 smi, 10 i2c
// - port 0 mode 00 mac, 01 phy, 10 rmii
// - three port 0 pins decode to two bits
// - port 0 pin 1 defaults clock direction
// - port 0 pin 0 defaults clock strength
// - port 0 pin 1 defaults turbo mii enable
// - address strap picks virtual phy address
// - led polarity bit sets output drive sense
// - eeprom strap picks eeprom size range
// - one shared pin level feeds two straps
`timescale 1ns/1ps
module hsl_strap_latch (
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic                  external_reset_pin_low,
   input  wire logic                  soft_reset,
   input  wire logic [2:0]            port0_select_pins,
   input  wire logic [5:0]            shared_pin_i,
   output logic [5:0]                 shared_pin_o,
   output logic [5:0]                 shared_pin_oe,
   input  wire logic [5:0]            led_on,
   input  wire logic                  vphy_wr_en,
   input  wire hsl_pkg::hsl_vphy_s    vphy_wr_data,
   output hsl_pkg::hsl_vphy_s         virtual_phy_special_ctrl_reg,
   output hsl_pkg::hsl_mgmt_e         mgmt_mode,
   output logic                       mgmt_reserved,
   output hsl_pkg::hsl_p0_mode_e      port0_iface_select,
   output logic                       port0_reserved,
   output logic                       eeprom_size_sel,
   output logic                       phy_addr_sel,
   output logic                       auto_mdix_strap_2,
   output logic                       auto_mdix_strap_1,
   output logic [5:0]                 led_pol,
   output logic                       straps_valid
);

   // ***************************************************************
   // state and capture
   // ***************************************************************
   hsl_pkg::hsl_state_e    state_q, state_d;
   hsl_pkg::hsl_strap_s    strap_q, strap_d;
   hsl_pkg::hsl_mgmt_e     mgmt_q, mgmt_d;
   hsl_pkg::hsl_p0_mode_e  p0_q, p0_d, p0_dec;
   logic                   capture;

   // the reserved flag is rebuilt from the registered mode, so the live one is left open
   hsl_port0_decode u_p0_dec (
      .port0_select_pins  (port0_select_pins),
      .port0_iface_select (p0_dec),
      .port0_reserved     ()
   );

   // a pin reset pulls the block back to wait; the soft reset does not
   assign capture = (state_q == hsl_pkg::HSL_ST_WAIT) && !external_reset_pin_low;

   always_comb begin
      state_d = state_q;
      strap_d = strap_q;
      mgmt_d  = mgmt_q;
      p0_d    = p0_q;
      if (external_reset_pin_low) begin
         state_d = hsl_pkg::HSL_ST_WAIT;
      end else if (capture) begin
         state_d = hsl_pkg::HSL_ST_HOLD;
         // pins are the only source; no loader input exists on this block
         strap_d.mgmt_bits    = {shared_pin_i[hsl_pkg::PIN_MGMT1], shared_pin_i[hsl_pkg::PIN_MGMT0]};
         strap_d.eeprom_size  = shared_pin_i[hsl_pkg::PIN_EESIZE];
         strap_d.phy_addr_sel = shared_pin_i[hsl_pkg::PIN_PHYADDR];
         strap_d.auto_mdix_2  = shared_pin_i[hsl_pkg::PIN_MDIX2];
         strap_d.auto_mdix_1  = shared_pin_i[hsl_pkg::PIN_MDIX1];
         strap_d.led_pol      = shared_pin_i;
         strap_d.p0_pins      = port0_select_pins;
         p0_d                 = p0_dec;
         unique case ({shared_pin_i[hsl_pkg::PIN_MGMT1], shared_pin_i[hsl_pkg::PIN_MGMT0]})
            2'h1: mgmt_d = hsl_pkg::HSL_MGMT_SMI;
            2'h2: mgmt_d = hsl_pkg::HSL_MGMT_I2C;
            2'h0: mgmt_d = hsl_pkg::HSL_MGMT_RSVD_LO;
            2'h3: mgmt_d = hsl_pkg::HSL_MGMT_RSVD_HI;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= hsl_pkg::HSL_ST_WAIT;
         strap_q <= '0;
         mgmt_q  <= hsl_pkg::HSL_MGMT_RSVD_LO;
         p0_q    <= hsl_pkg::HSL_P0_MII_MAC;
      end else begin
         state_q <= state_d;
         strap_q <= strap_d;
         mgmt_q  <= mgmt_d;
         p0_q    <= p0_d;
      end
   end

   // ***************************************************************
   // virtual phy special control bits
   // ***************************************************************
   // defaults reload on capture and on soft reset, so software writes
   // are lost on any reset but the straps themselves survive a soft one
   hsl_pkg::hsl_vphy_s vphy_q, vphy_d, vphy_dflt;

   always_comb begin
      vphy_dflt.refclk_dir = strap_d.p0_pins[hsl_pkg::P0_PIN_DIR];
      vphy_dflt.clk_drive  = strap_d.p0_pins[hsl_pkg::P0_PIN_DRIVE];
      vphy_dflt.turbo_en   = strap_d.p0_pins[hsl_pkg::P0_PIN_DIR];
      vphy_d = vphy_q;
      if (capture || soft_reset) begin
         vphy_d = vphy_dflt;
      end else if (vphy_wr_en && state_q == hsl_pkg::HSL_ST_HOLD) begin
         vphy_d = vphy_wr_data;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         vphy_q <= hsl_pkg::VPHY_RST;
      end else begin
         vphy_q <= vphy_d;
      end
   end

   // ***************************************************************
   // shared pin drive
   // ***************************************************************
   // pins float while waiting so the board pulls set the sampled level
   logic [5:0] pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;

   always_comb begin
      pin_o_d  = led_on ^ strap_q.led_pol;
      pin_oe_d = (state_d == hsl_pkg::HSL_ST_HOLD) ? 6'h3f : 6'h00;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_o_q  <= hsl_pkg::LED_POL_RST;
         pin_oe_q <= 6'h00;
      end else begin
         pin_o_q  <= pin_o_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign shared_pin_o                 = pin_o_q;
   assign shared_pin_oe                = pin_oe_q;
   assign virtual_phy_special_ctrl_reg = vphy_q;
   assign mgmt_mode                    = mgmt_q;
   assign mgmt_reserved                = (mgmt_q == hsl_pkg::HSL_MGMT_RSVD_LO)
                                         || (mgmt_q == hsl_pkg::HSL_MGMT_RSVD_HI);
   assign port0_iface_select           = p0_q;
   assign port0_reserved               = (p0_q == hsl_pkg::HSL_P0_RSVD);
   assign eeprom_size_sel              = strap_q.eeprom_size;
   assign phy_addr_sel                 = strap_q.phy_addr_sel;
   assign auto_mdix_strap_2            = strap_q.auto_mdix_2;
   assign auto_mdix_strap_1            = strap_q.auto_mdix_1;
   assign led_pol                      = strap_q.led_pol;
   assign straps_valid                 = (state_q == hsl_pkg::HSL_ST_HOLD);

   // ***************************************************************
   // assertions
   // ***************************************************************
   a_hold_stable: assert property (@(posedge core_clk) disable iff (!resetn)
      state_q == hsl_pkg::HSL_ST_HOLD && !external_reset_pin_low |=> $stable(strap_q))
      else $error("straps changed while held");

   a_soft_no_sample: assert property (@(posedge core_clk) disable iff (!resetn)
      soft_reset && state_q == hsl_pkg::HSL_ST_HOLD && !external_reset_pin_low
      |=> $stable(strap_q) && state_q == hsl_pkg::HSL_ST_HOLD)
      else $error("soft reset resampled straps");

   // keyed on the rise of valid: capture is already high at the edge that releases reset
   a_pin_sample: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(straps_valid) |-> strap_q.led_pol == $past(shared_pin_i)
      && strap_q.mgmt_bits == $past(shared_pin_i[4:3]) && eeprom_size_sel == $past(shared_pin_i[2]))
      else $error("shared pin not latched into both straps");

   a_mgmt_decode: assert property (@(posedge core_clk) disable iff (!resetn)
      straps_valid |-> (strap_q.mgmt_bits == 2'h1) == (mgmt_mode == hsl_pkg::HSL_MGMT_SMI)
      && (strap_q.mgmt_bits == 2'h2) == (mgmt_mode == hsl_pkg::HSL_MGMT_I2C))
      else $error("management mode decode wrong");

   a_p0_decode: assert property (@(posedge core_clk) disable iff (!resetn)
      straps_valid |-> (strap_q.p0_pins == 3'h0) == (port0_iface_select == hsl_pkg::HSL_P0_MII_MAC)
      && (strap_q.p0_pins == 3'h7) == port0_reserved
      && (strap_q.p0_pins[2] && strap_q.p0_pins != 3'h7) == (port0_iface_select == hsl_pkg::HSL_P0_RMII_PHY))
      else $error("port 0 mode decode wrong");

   a_vphy_default: assert property (@(posedge core_clk) disable iff (!resetn)
      soft_reset && state_q == hsl_pkg::HSL_ST_HOLD && !external_reset_pin_low
      |=> virtual_phy_special_ctrl_reg.refclk_dir == strap_q.p0_pins[1]
      && virtual_phy_special_ctrl_reg.turbo_en == strap_q.p0_pins[1]
      && virtual_phy_special_ctrl_reg.clk_drive == strap_q.p0_pins[0])
      else $error("virtual phy defaults not reloaded");

   a_led_sense: assert property (@(posedge core_clk) disable iff (!resetn)
      straps_valid && $past(straps_valid) |-> shared_pin_o == ($past(led_on) ^ $past(led_pol)))
      else $error("led drive sense wrong");

   a_pins_float: assert property (@(posedge core_clk) disable iff (!resetn)
      external_reset_pin_low |=> shared_pin_oe == 6'h00 && !straps_valid)
      else $error("shared pins driven during pin reset");

   c_capture:    cover property (@(posedge core_clk) disable iff (!resetn) capture ##1 straps_valid);
   c_soft_reset: cover property (@(posedge core_clk) disable iff (!resetn) straps_valid && soft_reset);
   c_pin_reset:  cover property (@(posedge core_clk) disable iff (!resetn)
      straps_valid ##1 external_reset_pin_low ##1 !external_reset_pin_low ##1 straps_valid);

endmodule

/* File: verif/hsl_board_pulls.sv */
// board pull resistors on the strap pins and the shared led pins
`timescale 1ns/1ps
module hsl_board_pulls (
   input  wire logic [5:0] pull_shared,
   input  wire logic [2:0] pull_port0,
   input  wire logic [5:0] shared_pin_o,
   input  wire logic [5:0] shared_pin_oe,
   output logic [5:0]      shared_pin_i,
   output logic [2:0]      port0_select_pins
);
   // a released pin settles to its resistor level; that level is what the strap sees
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         shared_pin_i[i] = shared_pin_oe[i] ? shared_pin_o[i] : pull_shared[i];
      end
      port0_select_pins = pull_port0;
   end
endmodule

/* File: verif/tb_hard_strap_latch_decode.sv */
// self-checking testbench for the hard strap latch and decode block
`timescale 1ns/1ps
module tb_hard_strap_latch_decode;
   logic                       core_clk;
   logic                       resetn;
   logic                       ext_rst;
   logic                       soft_reset;
   logic [5:0]                 pull_shared;
   logic [2:0]                 pull_port0;
   logic [2:0]                 p0_pins;
   logic [5:0]                 pin_i;
   logic [5:0]                 pin_o;
   logic [5:0]                 pin_oe;
   logic [5:0]                 led_on;
   logic                       vphy_wr_en;
   hsl_pkg::hsl_vphy_s         vphy_wr_data;
   hsl_pkg::hsl_vphy_s         vphy;
   hsl_pkg::hsl_mgmt_e         mgmt_mode;
   hsl_pkg::hsl_p0_mode_e      p0_mode;
   logic                       mgmt_rsvd;
   logic                       p0_rsvd;
   logic                       ee_sel;
   logic                       addr_sel;
   logic                       mdix2;
   logic                       mdix1;
   logic [5:0]                 led_pol;
   logic                       valid;
   int                         miscompares;
   int                         comparisons;

   hsl_board_pulls board (.pull_shared(pull_shared), .pull_port0(pull_port0), .shared_pin_o(pin_o),
      .shared_pin_oe(pin_oe), .shared_pin_i(pin_i), .port0_select_pins(p0_pins));

   hsl_strap_latch dut (.core_clk(core_clk), .resetn(resetn), .external_reset_pin_low(ext_rst),
      .soft_reset(soft_reset), .port0_select_pins(p0_pins), .shared_pin_i(pin_i), .shared_pin_o(pin_o),
      .shared_pin_oe(pin_oe), .led_on(led_on), .vphy_wr_en(vphy_wr_en), .vphy_wr_data(vphy_wr_data),
      .virtual_phy_special_ctrl_reg(vphy), .mgmt_mode(mgmt_mode), .mgmt_reserved(mgmt_rsvd),
      .port0_iface_select(p0_mode), .port0_reserved(p0_rsvd), .eeprom_size_sel(ee_sel),
      .phy_addr_sel(addr_sel), .auto_mdix_strap_2(mdix2), .auto_mdix_strap_1(mdix1),
      .led_pol(led_pol), .straps_valid(valid));

   // ***************************************************************
   // clock, watchdog and verdict
   // ***************************************************************
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // the whole run needs well under 300 cycles
   initial begin
      repeat (2000) @(posedge core_clk);
      miscompares++;
      results();
   end

   task automatic results();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic check_straps(input logic [5:0] sh, input logic [2:0] p);
      logic [1:0] m;
      m = (p == 3'h0) ? 2'h0 : (p < 3'h4) ? 2'h1 : (p < 3'h7) ? 2'h2 : 2'h3;
      compare("port0_iface_select", {6'h00, m}, {6'h00, p0_mode});
      compare("port0_reserved", {7'h00, p == 3'h7}, {7'h00, p0_rsvd});
      compare("mgmt_mode", {6'h00, sh[4:3]}, {6'h00, mgmt_mode});
      compare("mgmt_reserved", {7'h00, sh[4] == sh[3]}, {7'h00, mgmt_rsvd});
      compare("vphy defaults", {5'h00, p[1], p[0], p[1]}, {5'h00, vphy});
      compare("led_pol", {2'h0, sh}, {2'h0, led_pol});
      compare("single straps", {4'h0, sh[5], sh[2], sh[1], sh[0]}, {4'h0, addr_sel, ee_sel, mdix2, mdix1});
      compare("valid and oe", 8'h7f, {1'b0, valid, pin_oe});
   endtask

   task automatic por_capture(input logic [5:0] sh, input logic [2:0] p);
      pull_shared <= sh;
      pull_port0 <= p;
      resetn <= 1'b0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      check_straps(sh, p);
      @(posedge core_clk);
   endtask

   task automatic hold_and_reloads();
      por_capture(6'h15, 3'h5);
      pull_shared <= 6'h2a;
      pull_port0 <= 3'h2;
      led_on <= 6'h2d;
      repeat (2) @(posedge core_clk);
      #1;
      compare("shared_pin_o", 8'h38, {2'h0, pin_o});
      @(posedge core_clk);
      vphy_wr_en <= 1'b1;
      vphy_wr_data <= 3'h5;
      @(posedge core_clk);
      vphy_wr_en <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      compare("vphy written", 8'h05, {5'h00, vphy});
      @(posedge core_clk);
      soft_reset <= 1'b1;
      @(posedge core_clk);
      soft_reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check_straps(6'h15, 3'h5);
      @(posedge core_clk);
      ext_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      ext_rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check_straps(6'h2a, 3'h2);
   endtask

   initial begin
      miscompares = 0;
      comparisons = 0;
      resetn = 1'b0;
      ext_rst = 1'b0;
      soft_reset = 1'b0;
      pull_shared = 6'h00;
      pull_port0 = 3'h0;
      led_on = 6'h00;
      vphy_wr_en = 1'b0;
      vphy_wr_data = 3'h0;
      @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         por_capture({i[2:0], ~i[2:0]}, i[2:0]);
      end
      hold_and_reloads();
      results();
   end
endmodule
